// ===== src/wsp_player.v
// Purpose: Waveform sequence player with Wishbone register access
// Assumes: Converter path maps wave number and point to a sample
// Notes:   Single clock, synchronous active high reset
//
// Contract
// [RULE1] Table holds up to 1024 units: wave number, length, repeat.
// [RULE2] Units may only name built-in waveforms below the wave limit.
// [RULE3] One sample per rate tick; sequence time is sum of spans.
// [RULE4] Internal source replays the sequence continuously, no trigger.
// [RULE5] Each manual trigger request gives exactly one triggered step; requests made while the player is playing are dropped.
// [RULE6] Each valid external edge gives one triggered step.
// [RULE7] Trigger mode matters only for manual or external source.
// [RULE8] Unit mode: each trigger plays the next unit with all repeats.
// [RULE9] Cycle mode: each trigger plays one waveform cycle.
// [RULE10] External trigger takes rising or falling edge per edge bit.
// [RULE11] Unit sync mode: one sync pulse per unit played.
// [RULE12] Cycle sync mode: one sync pulse per waveform cycle played.
// [RULE13] Sync rises at waveform switch, high for half its span.
// [RULE14] Under manual or external source, sync follows trigger events.
// [RULE15] Sequence table is volatile storage.
// [RULE16] Units play in ascending order, wrapping to the first.
// [RULE17] Samples and sync share frequency and phase, no offset.
`timescale 1ns/1ps
`default_nettype none
`include "wsp_defs.vh"

module wsp_player
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [5:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        ext_trig_i,
    output reg         sample_valid_o,
    output reg  [7:0]  sample_wave_o,
    output reg  [15:0] sample_point_o,
    output reg         sync_o
);

    reg  [5:0]             ctrl;
    reg  [10:0]            units;
    reg  [15:0]            rate_div;
    reg  [`WSP_IDX_W-1:0]  tab_idx;
    reg  [1:0]             state;
    reg  [`WSP_IDX_W-1:0]  unit_idx;
    reg  [15:0]            point;
    reg  [15:0]            rep;
    reg  [15:0]            rate_cnt;
    reg  [31:0]            sync_left;
    reg                    ext_prev;
    reg                    man_req;
    reg                    trig_ovr;

    wire                   req;
    wire                   wr;
    wire [3:0]             reg_idx;
    wire [31:0]            mask;
    wire [31:0]            wdat;
    wire [7:0]             b_wave;
    wire [15:0]            b_len;
    wire [15:0]            b_rep;
    wire [7:0]             p_wave;
    wire [15:0]            p_len;
    wire [15:0]            p_rep;
    wire                   run;
    wire [1:0]             src;
    wire                   tmode;
    wire                   edge_fall;
    wire                   smode;
    wire                   triggered;
    wire                   ext_edge;
    wire                   trig;
    wire                   tick;
    wire [15:0]            last_point;
    wire [15:0]            last_rep;
    wire                   end_cycle;
    wire                   end_unit;
    wire                   seg_start;
    wire [31:0]            span;
    wire [31:0]            half;
    wire [`WSP_IDX_W-1:0]  next_unit;
    wire                   wave_ok;
    // Full-width merge results, cut on purpose where they are stored
    wire [31:0]            ctrl_w;
    wire [31:0]            rate_w;
    wire [31:0]            idx_w;
    wire [31:0]            tab_w;

    assign req     = cyc_i & stb_i & ~ack_o;
    assign wr      = req & we_i;
    assign reg_idx = adr_i[5:2];
    assign mask    = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};

    // Byte lanes not selected keep their old contents
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [31:0] m;
        begin
            merge = (old & ~m) | (dat & m);
        end
    endfunction

    assign wdat = dat_i & mask;

    assign run       = ctrl[`WSP_CTRL_RUN];
    assign src       = ctrl[`WSP_CTRL_SRC_HI:`WSP_CTRL_SRC_LO];
    assign tmode     = ctrl[`WSP_CTRL_TMODE];
    assign edge_fall = ctrl[`WSP_CTRL_EDGE];
    assign smode     = ctrl[`WSP_CTRL_SMODE];
    assign triggered = (src == `WSP_SRC_MAN) || (src == `WSP_SRC_EXT);

    // Merged write values; only the low bits of each are kept
    assign ctrl_w = merge({26'h000_0000, ctrl}, dat_i, mask);
    assign rate_w = merge({16'h0000, rate_div}, dat_i, mask);
    assign idx_w  = merge({22'h00_0000, tab_idx}, dat_i, mask);
    assign tab_w  = (reg_idx == `WSP_REG_WAVE) ?
                    merge({24'h0000_00, b_wave}, dat_i, mask) :
                    (reg_idx == `WSP_REG_LEN) ?
                    merge({16'h0000, b_len}, dat_i, mask) :
                    merge({16'h0000, b_rep}, dat_i, mask);

    // Refuse wave numbers outside the built-in set
    // Compared at full width so high bits cannot alias a legal number
    assign wave_ok = (tab_w < {24'h0000_00, `WSP_WAVE_LIMIT}); // [RULE2]

    wsp_table u_table
    (
        .clk_i       (clk_i),
        .we_wave_i   (wr && reg_idx == `WSP_REG_WAVE && wave_ok),
        .we_len_i    (wr && reg_idx == `WSP_REG_LEN),
        .we_rep_i    (wr && reg_idx == `WSP_REG_REP),
        .wr_idx_i    (tab_idx), // [RULE1]
        .din_i       (tab_w[15:0]),
        .rd_a_idx_i  (tab_idx),
        .rd_a_wave_o (b_wave),
        .rd_a_len_o  (b_len),
        .rd_a_rep_o  (b_rep),
        .rd_b_idx_i  (unit_idx),
        .rd_b_wave_o (p_wave),
        .rd_b_len_o  (p_len),
        .rd_b_rep_o  (p_rep)
    );

    // A zero length or repeat count plays as one
    assign last_point = (p_len == 16'h0000) ? 16'h0000 : p_len - 16'h0001;
    assign last_rep   = (p_rep == 16'h0000) ? 16'h0000 : p_rep - 16'h0001;

    // Edge detect on the synchronous trigger input
    assign ext_edge = edge_fall ? (ext_prev & ~ext_trig_i)
                                : (~ext_prev & ext_trig_i); // [RULE10]
    assign trig = (src == `WSP_SRC_MAN) ? man_req // [RULE5]
                : (src == `WSP_SRC_EXT) ? (ext_edge | trig_ovr) // [RULE6]
                : 1'b0;

    assign tick = (state == `WSP_ST_PLAY) && (rate_cnt == rate_div); // [RULE3]
    assign end_cycle = (point == last_point);
    assign end_unit  = end_cycle && (rep == last_rep);
    assign next_unit = ({1'b0, unit_idx} + 11'h001 >= units) ?
                       {`WSP_IDX_W{1'b0}} :
                       unit_idx + {{(`WSP_IDX_W-1){1'b0}}, 1'b1}; // [RULE16]

    // Sync span: whole unit or one cycle, high for half of it
    assign seg_start = (point == 16'h0000) &&
                       (smode || rep == 16'h0000); // [RULE11] [RULE12]
    assign span = smode ? {16'h0000, last_point} + 32'h0000_0001
                : ({16'h0000, last_point} + 32'h0000_0001) *
                  ({16'h0000, last_rep} + 32'h0000_0001);
    assign half = (span[31:1] == 31'h0000_0000) ? 32'h0000_0001
                : {1'b0, span[31:1]}; // [RULE13]

    // Wishbone slave: ack one cycle after request, dropped next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o    <= 1'b0;
            dat_o    <= 32'h0000_0000;
            ctrl     <= `WSP_CTRL_RST;
            units    <= `WSP_UNITS_RST;
            rate_div <= `WSP_RATE_RST;
            tab_idx  <= {`WSP_IDX_W{1'b0}};
            man_req  <= 1'b0;
        end
        else
        begin
            ack_o   <= req;
            man_req <= 1'b0;
            if (wr)
            begin
                case (reg_idx)
                    `WSP_REG_CTRL:
                        ctrl <= ctrl_w[5:0];
                    `WSP_REG_UNITS:
                    begin
                        // Unit count is limited to 1..1024
                        if (wdat[10:0] != 11'h000 &&
                            wdat[31:0] <= 32'h0000_0400)
                            units <= wdat[10:0]; // [RULE1]
                    end
                    `WSP_REG_RATE:
                        rate_div <= rate_w[15:0];
                    `WSP_REG_TRIG:
                        man_req <= wdat[0]; // [RULE5]
                    `WSP_REG_INDEX:
                        tab_idx <= idx_w[`WSP_IDX_W-1:0];
                    default:
                        ;
                endcase
            end
            if (req && !we_i)
            begin
                case (reg_idx)
                    `WSP_REG_CTRL:   dat_o <= {26'h000_0000, ctrl};
                    `WSP_REG_UNITS:  dat_o <= {21'h00_0000, units};
                    `WSP_REG_RATE:   dat_o <= {16'h0000, rate_div};
                    `WSP_REG_INDEX:  dat_o <= {22'h00_0000, tab_idx};
                    `WSP_REG_WAVE:   dat_o <= {24'h0000_00, b_wave};
                    `WSP_REG_LEN:    dat_o <= {16'h0000, b_len};
                    `WSP_REG_REP:    dat_o <= {16'h0000, b_rep};
                    `WSP_REG_STATUS: dat_o <= {2'b00, rep, sync_o, 1'b0,
                                               state, unit_idx};
                    default:         dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Player state, counters and sample stream
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state          <= `WSP_ST_IDLE;
            unit_idx       <= {`WSP_IDX_W{1'b0}};
            point          <= 16'h0000;
            rep            <= 16'h0000;
            rate_cnt       <= 16'h0000;
            sync_left      <= 32'h0000_0000;
            // Same as the idle-low pin, so reset adds no rising edge
            ext_prev       <= 1'b0;
            trig_ovr       <= 1'b0;
            sample_valid_o <= 1'b0;
            sample_wave_o  <= 8'h00;
            sample_point_o <= 16'h0000;
            sync_o         <= 1'b0;
        end
        else
        begin
            ext_prev       <= ext_trig_i;
            trig_ovr       <= 1'b0;
            sample_valid_o <= 1'b0;
            if (!run)
            begin
                state     <= `WSP_ST_IDLE;
                unit_idx  <= {`WSP_IDX_W{1'b0}};
                point     <= 16'h0000;
                rep       <= 16'h0000;
                rate_cnt  <= 16'h0000;
                sync_left <= 32'h0000_0000;
                sync_o    <= 1'b0;
            end
            else
            begin
                case (state)
                    `WSP_ST_IDLE:
                    begin
                        rate_cnt <= 16'h0000;
                        // Tmode ignored under the internal source
                        if (triggered)
                            state <= `WSP_ST_WAIT; // [RULE7]
                        else
                            state <= `WSP_ST_PLAY; // [RULE4]
                    end
                    `WSP_ST_WAIT:
                    begin
                        rate_cnt <= 16'h0000;
                        if (!triggered)
                            state <= `WSP_ST_PLAY;
                        else if (trig)
                            state <= `WSP_ST_PLAY; // [RULE14]
                    end
                    `WSP_ST_PLAY:
                    begin
                        if (tick)
                            rate_cnt <= 16'h0000;
                        else
                            rate_cnt <= rate_cnt + 16'h0001;
                        // Edge during the last sample is held over;
                        // it lives one cycle, so earlier edges still drop
                        if (src == `WSP_SRC_EXT && ext_edge)
                            trig_ovr <= 1'b1; // [RULE6]
                        if (tick)
                        begin
                            sample_valid_o <= 1'b1;
                            sample_wave_o  <= p_wave;
                            sample_point_o <= point;
                            // Sync edge on the same sample as the switch
                            if (seg_start)
                            begin
                                sync_o    <= 1'b1; // [RULE17]
                                sync_left <= half - 32'h0000_0001;
                            end
                            else if (sync_left != 32'h0000_0000)
                                sync_left <= sync_left - 32'h0000_0001;
                            else
                                sync_o <= 1'b0;
                            if (end_unit)
                            begin
                                point    <= 16'h0000;
                                rep      <= 16'h0000;
                                unit_idx <= next_unit; // [RULE16]
                            end
                            else if (end_cycle)
                            begin
                                point <= 16'h0000;
                                rep   <= rep + 16'h0001;
                            end
                            else
                                point <= point + 16'h0001;
                            if (triggered && end_cycle &&
                                (tmode || end_unit))
                                state <= `WSP_ST_WAIT; // [RULE8] [RULE9]
                        end
                    end
                    default:
                        state <= `WSP_ST_IDLE;
                endcase
            end
        end
    end

endmodule // wsp_player

`default_nettype wire

// ===== src/wsp_defs.vh
// Purpose: Constants shared by the waveform sequence player
// Assumes: 32-bit classic Wishbone, word aligned registers
// Notes:   Definitions only
`ifndef WSP_DEFS_VH
`define WSP_DEFS_VH

// Register word indexes (byte address = index * 4)
`define WSP_REG_CTRL    4'h0
`define WSP_REG_UNITS   4'h1
`define WSP_REG_RATE    4'h2
`define WSP_REG_TRIG    4'h3
`define WSP_REG_INDEX   4'h4
`define WSP_REG_WAVE    4'h5
`define WSP_REG_LEN     4'h6
`define WSP_REG_REP     4'h7
`define WSP_REG_STATUS  4'h8

// Control field positions
`define WSP_CTRL_RUN    0
`define WSP_CTRL_SRC_LO 1
`define WSP_CTRL_SRC_HI 2
`define WSP_CTRL_TMODE  3
`define WSP_CTRL_EDGE   4
`define WSP_CTRL_SMODE  5

// Trigger sources
`define WSP_SRC_INT     2'h0
`define WSP_SRC_MAN     2'h1
`define WSP_SRC_EXT     2'h2

// Table geometry and limits
`define WSP_DEPTH       1024
`define WSP_IDX_W       10
`define WSP_WAVE_LIMIT  8'hc8

// Reset values
`define WSP_CTRL_RST    6'h00
`define WSP_UNITS_RST   11'h001
`define WSP_RATE_RST    16'h0000

// Player states
`define WSP_ST_IDLE     2'h0
`define WSP_ST_WAIT     2'h1
`define WSP_ST_PLAY     2'h2

`endif

// ===== src/wsp_table.v
// Purpose: Sequence table storage, one entry per unit
// Assumes: Single write port, two combinational read ports
// Notes:   No reset, contents are volatile
`timescale 1ns/1ps
`default_nettype none
`include "wsp_defs.vh"

module wsp_table
(
    input  wire                   clk_i,
    input  wire                   we_wave_i,
    input  wire                   we_len_i,
    input  wire                   we_rep_i,
    input  wire [`WSP_IDX_W-1:0]  wr_idx_i,
    input  wire [15:0]            din_i,
    input  wire [`WSP_IDX_W-1:0]  rd_a_idx_i,
    output wire [7:0]             rd_a_wave_o,
    output wire [15:0]            rd_a_len_o,
    output wire [15:0]            rd_a_rep_o,
    input  wire [`WSP_IDX_W-1:0]  rd_b_idx_i,
    output wire [7:0]             rd_b_wave_o,
    output wire [15:0]            rd_b_len_o,
    output wire [15:0]            rd_b_rep_o
);

    // Plain flops, nothing survives power loss
    reg [7:0]  wave_mem [0:`WSP_DEPTH-1]; // [RULE15]
    reg [15:0] len_mem  [0:`WSP_DEPTH-1];
    reg [15:0] rep_mem  [0:`WSP_DEPTH-1];

    always @(posedge clk_i)
    begin
        if (we_wave_i)
            wave_mem[wr_idx_i] <= din_i[7:0];
        if (we_len_i)
            len_mem[wr_idx_i] <= din_i;
        if (we_rep_i)
            rep_mem[wr_idx_i] <= din_i;
    end

    assign rd_a_wave_o = wave_mem[rd_a_idx_i];
    assign rd_a_len_o  = len_mem[rd_a_idx_i];
    assign rd_a_rep_o  = rep_mem[rd_a_idx_i];
    assign rd_b_wave_o = wave_mem[rd_b_idx_i];
    assign rd_b_len_o  = len_mem[rd_b_idx_i];
    assign rd_b_rep_o  = rep_mem[rd_b_idx_i];

endmodule // wsp_table

`default_nettype wire

// ===== testbench/wsp_player_props.sv
// Purpose: Port level checks for the sequence player
// Assumes: Full word writes to the rate register
// Notes:   Rate divider is snooped from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "wsp_defs.vh"

module wsp_player_props
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_o,
    input  wire logic        sample_valid_o,
    input  wire logic [7:0]  sample_wave_o,
    input  wire logic [15:0] sample_point_o,
    input  wire logic        sync_o
);
    logic [15:0] rate;
    logic [15:0] gap;
    logic [15:0] last_pt;
    logic [7:0]  last_wv;
    wire         req_taken = cyc_i && stb_i && !ack_o;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Gap saturates so a long stall cannot wrap into a false match
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rate <= 16'h0000;
            gap <= 16'h0000;
            last_pt <= 16'h0000;
            last_wv <= 8'h00;
        end
        else
        begin
            if (req_taken && we_i && adr_i[5:2] == `WSP_REG_RATE)
                rate <= dat_i[15:0];
            if (sample_valid_o)
            begin
                gap <= 16'h0001;
                last_pt <= sample_point_o;
                last_wv <= sample_wave_o;
            end
            else if (gap != 16'hffff)
                gap <= gap + 16'h0001;
        end
    end

    a_ack_answer: assert property (req_taken |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && !sample_valid_o && !sync_o)
        else $error("outputs active after reset edge");
    a_wave_builtin: assert property (
        sample_valid_o |-> sample_wave_o < `WSP_WAVE_LIMIT)
        else $error("sample names a wave beyond the built-in set");
    a_rate_gap: assert property (
        sample_valid_o && sample_point_o != 16'h0000
        |-> gap == rate + 16'h0001)
        else $error("sample spacing differs from rate divider");
    a_point_step: assert property (
        sample_valid_o && sample_point_o != 16'h0000
        |-> sample_point_o == last_pt + 16'h0001
            && $stable(sample_wave_o))
        else $error("points not consecutive within one wave");
    a_sync_with_sample: assert property (
        $rose(sync_o) |-> sample_valid_o)
        else $error("sync rose away from a sample");
    a_sync_at_switch: assert property (
        $rose(sync_o) |-> sample_point_o == 16'h0000)
        else $error("sync rose away from a wave start");
endmodule // wsp_player_props

bind wsp_player wsp_player_props i_wsp_player_props (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
    .sample_valid_o(sample_valid_o), .sample_wave_o(sample_wave_o),
    .sample_point_o(sample_point_o), .sync_o(sync_o));
`default_nettype wire

// ===== testbench/wsp_far_end.sv
// Purpose: Trigger source and sample sink beside the player
// Assumes: Converter path never stalls the stream
// Notes:   Counters only grow; the bench works with deltas
`timescale 1ns/1ps
`default_nettype none

module wsp_far_end
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        valid_i,
    input  wire logic [7:0]  wave_i,
    input  wire logic        sync_i,
    output var  logic        ext_trig_o,
    output var  logic [15:0] samp_cnt_o,
    output var  logic [15:0] sync_cnt_o,
    output var  logic [7:0]  last_wave_o
);
    logic sync_q;

    initial ext_trig_o = 1'b0;

    task automatic set_idle(input logic v);
        @(posedge clk_i);
        ext_trig_o <= v;
    endtask

    // Return to idle makes the opposite edge, which must be ignored
    task automatic fire(input logic idle);
        @(posedge clk_i);
        ext_trig_o <= !idle;
        repeat (4) @(posedge clk_i);
        ext_trig_o <= idle;
    endtask

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            samp_cnt_o <= 16'h0000;
            sync_cnt_o <= 16'h0000;
            last_wave_o <= 8'h00;
            sync_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_i;
            if (valid_i)
            begin
                samp_cnt_o <= samp_cnt_o + 16'h0001;
                last_wave_o <= wave_i;
            end
            if (sync_i && !sync_q)
                sync_cnt_o <= sync_cnt_o + 16'h0001;
        end
    end
endmodule // wsp_far_end
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the sequence player
// Assumes: Two-unit table, rate divider 1
// Notes:   Trigger steps are paced by polling the player state
`timescale 1ns/1ps
`default_nettype none
`include "wsp_defs.vh"

module tb_top;
    typedef struct {
        logic [5:0] ctrl;
        int         trg;
        logic       b2b;
        int         smp;
        int         syn;
        logic [7:0] wv;
    } wsp_row_t;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic        ack;
    logic        ext;
    logic        valid;
    logic [7:0]  wave;
    logic [15:0] point;
    logic        sync;
    logic [15:0] samp_cnt;
    logic [15:0] sync_cnt;
    logic [7:0]  last_wave;
    logic [31:0] q;
    int          errors = 0;
    int          tests_run = 0;
    wsp_row_t    rows [0:6];

    always #2 clk_i = ~clk_i;

    wsp_player i_wsp_player (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
        .dat_o(dat_r), .ack_o(ack), .ext_trig_i(ext),
        .sample_valid_o(valid), .sample_wave_o(wave),
        .sample_point_o(point), .sync_o(sync));
    wsp_far_end i_wsp_far_end (.clk_i(clk_i), .rst_i(rst_i),
        .valid_i(valid), .wave_i(wave), .sync_i(sync), .ext_trig_o(ext),
        .samp_cnt_o(samp_cnt), .sync_cnt_o(sync_cnt),
        .last_wave_o(last_wave));

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang();
        errors++;
        print_verdict();
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle; the slave's answer time is not assumed
    task automatic wb(input logic w, input logic [3:0] i,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'hf;
        dat_w <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 50)
            hang();
    endtask

    task automatic rd(input logic [3:0] i, input logic [31:0] e,
                      input string nm);
        wb(1'b0, i, 32'h0000_0000);
        chk(nm, q, e);
    endtask

    task automatic put(input logic [3:0] i, input logic [31:0] d);
        wb(1'b1, i, d);
    endtask

    task automatic wait_st(input logic [1:0] st);
        int k;
        k = 0;
        do
        begin
            wb(1'b0, `WSP_REG_STATUS, 32'h0000_0000);
            k++;
        end
        while (q[11:10] !== st && k < 300);
        if (k == 300)
            hang();
    endtask

    task automatic run_row(input wsp_row_t r);
        logic [15:0] s0;
        logic [15:0] y0;
        int          k;
        i_wsp_far_end.set_idle(r.ctrl[`WSP_CTRL_EDGE]);
        put(`WSP_REG_CTRL, {26'h000_0000, r.ctrl});
        s0 = samp_cnt;
        y0 = sync_cnt;
        put(`WSP_REG_CTRL, {26'h000_0000, r.ctrl | 6'h01});
        for (k = 0; k < r.trg; k++)
        begin
            if (!r.b2b || k == 0)
                wait_st(`WSP_ST_WAIT);
            if (r.ctrl[2:1] == `WSP_SRC_EXT)
                i_wsp_far_end.fire(r.ctrl[`WSP_CTRL_EDGE]);
            else
                put(`WSP_REG_TRIG, 32'h0000_0001);
        end
        k = 0;
        while (16'(samp_cnt - s0) < r.smp && k < 4000)
        begin
            @(posedge clk_i);
            k++;
        end
        if (k == 4000)
            hang();
        if (r.trg > 0)
            wait_st(`WSP_ST_WAIT);
        s0 = samp_cnt - s0;
        y0 = sync_cnt - y0;
        chk("samples", {16'h0000, s0}, r.smp);
        chk("syncs", {16'h0000, y0}, r.syn);
        chk("last wave", {24'h00_0000, last_wave}, r.wv);
        put(`WSP_REG_CTRL, 32'h0000_0000);
    endtask

    initial
    begin
        rows[0] = '{6'h02, 1, 1'b0, 8, 1, 8'h01};
        rows[1] = '{6'h2a, 1, 1'b0, 4, 1, 8'h01};
        rows[2] = '{6'h22, 2, 1'b0, 14, 5, 8'h03};
        rows[3] = '{6'h0c, 3, 1'b0, 10, 2, 8'h03};
        rows[4] = '{6'h34, 2, 1'b0, 14, 5, 8'h03};
        rows[5] = '{6'h2a, 6, 1'b0, 18, 6, 8'h01};
        rows[6] = '{6'h08, 0, 1'b0, 28, 4, 8'h03};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`WSP_REG_CTRL, 32'h0000_0000, "ctrl reset");
        rd(`WSP_REG_UNITS, 32'h0000_0001, "units reset");
        rd(`WSP_REG_RATE, 32'h0000_0000, "rate reset");
        put(`WSP_REG_INDEX, 32'h0000_0000);
        put(`WSP_REG_WAVE, 32'h0000_0001);
        put(`WSP_REG_LEN, 32'h0000_0004);
        put(`WSP_REG_REP, 32'h0000_0002);
        put(`WSP_REG_INDEX, 32'h0000_0001);
        put(`WSP_REG_WAVE, 32'h0000_0003);
        put(`WSP_REG_LEN, 32'h0000_0002);
        put(`WSP_REG_REP, 32'h0000_0003);
        put(`WSP_REG_UNITS, 32'h0000_0002);
        put(`WSP_REG_RATE, 32'h0000_0001);
        rd(`WSP_REG_LEN, 32'h0000_0002, "table len");
        foreach (rows[i])
            run_row(rows[i]);
        // Second trigger lands mid-play and must be dropped
        run_row('{6'h2a, 2, 1'b1, 4, 1, 8'h01});
        put(`WSP_REG_UNITS, 32'h0000_0000);
        rd(`WSP_REG_UNITS, 32'h0000_0002, "units zero");
        put(`WSP_REG_UNITS, 32'h0000_0401);
        rd(`WSP_REG_UNITS, 32'h0000_0002, "units over");
        put(`WSP_REG_UNITS, 32'h0000_0400);
        rd(`WSP_REG_UNITS, 32'h0000_0400, "units max");
        put(`WSP_REG_INDEX, 32'h0000_0000);
        put(`WSP_REG_WAVE, {24'h00_0000, `WSP_WAVE_LIMIT});
        rd(`WSP_REG_WAVE, 32'h0000_0001, "wave limit");
        put(`WSP_REG_WAVE, 32'h0000_00c7);
        rd(`WSP_REG_WAVE, 32'h0000_00c7, "wave top");
        rd(4'hf, 32'h0000_0000, "unmapped");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`WSP_REG_UNITS, 32'h0000_0001, "units rerun");
        rd(`WSP_REG_RATE, 32'h0000_0000, "rate rerun");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
